// ==== design/psc_ctrl.sv ====
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps

module psc_ctrl
(
    // APB clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock sources for the waveform core.
    input wire logic clk_pll_tick,
    input wire logic clk_io_tick,
    // Waveform core side.
    input wire psc_pkg::psc_outs_t core_active,
    input wire logic core_cycle_end,
    output logic core_tick,
    output logic core_run,
    output logic [2:0] overlap_protect_off,
    // Fault sources.
    input wire logic [2:0] fault_input_pin,
    input wire logic [2:0] comparator_out,
    // Power stage pins.
    output psc_pkg::psc_outs_t module_out,
    // Interrupt request.
    output logic irq
);
    import psc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    psc_state_t st; // Registered state.
    psc_state_t next_st; // Next state.
    logic wr_en; // Write access phase.
    logic rd_en; // Read setup phase.
    logic mapped; // Address hits a register.
    logic src_tick; // Selected input clock tick.
    logic [7:0] div_last; // Terminal count of prescaler.
    logic [2:0] raw_in; // Selected fault inputs.
    logic [2:0] fault_evt; // Significant fault events per module.
    logic [2:0] kill_a; // A outputs disabled.
    logic [2:0] kill_b; // B outputs disabled.
    logic kill_all; // All outputs disabled.
    logic halt_req; // Fault asks for a halt.
    logic [3:0] set_flags; // Hardware flag sets.
    logic [3:0] clr_flags; // Software flag clears.
    psc_outs_t gated; // Outputs after fault gating and swap.

    // Decode: is this a known register address?
    function automatic logic psc_hit(input logic [11:0] a);
        psc_hit = (a == PSC_OUTPUT_CONFIG_ADDR) || (a == PSC_RUN_CONTROL_ADDR) ||
                  (a == PSC_MODULE_INPUT0_ADDR) || (a == PSC_MODULE_INPUT1_ADDR) ||
                  (a == PSC_MODULE_INPUT2_ADDR) || (a == PSC_INTERRUPT_MASK_ADDR) ||
                  (a == PSC_INTERRUPT_FLAGS_ADDR);
    endfunction : psc_hit

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // The slave answers in the first access cycle; no wait states.
    assign pready = 1'b1;
    assign mapped = psc_hit(paddr);
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && pstrb[0] && mapped;
    // Read data is loaded in the setup cycle so that it stands at the access edge.
    assign rd_en = psel && !penable && !pwrite;
    assign prdata = st.prdata;

    // ------------------------------------------------------------
    // Clock source and prescaler
    // ------------------------------------------------------------
    // The selected source tick feeds a divider; code 00 passes it straight.
    always_comb
    begin
        src_tick = st.run_control[PSC_CLKSEL_BIT] ? clk_pll_tick : clk_io_tick;
        unique case (st.run_control[PSC_DIV_LSB +: 2])
            2'b00: div_last = 8'h00;
            2'b01: div_last = PSC_DIV4_LAST;
            2'b10: div_last = PSC_DIV32_LAST;
            2'b11: div_last = PSC_DIV256_LAST;
        endcase
    end
    assign core_tick = src_tick && (st.div_count == div_last) && st.running;
    assign core_run = st.running;

    // ------------------------------------------------------------
    // Fault input path, one copy per module
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_fault
            // Pin or comparator, then the level that counts as the event.
            assign raw_in[gi] = st.module_input_control[gi][PSC_ISEL_BIT] ? comparator_out[gi]
                                                                         : fault_input_pin[gi];
            assign fault_evt[gi] = (st.module_input_control[gi][PSC_FILT_BIT] ? st.filtered[gi]
                                                                             : raw_in[gi])
                                   == st.module_input_control[gi][PSC_LEV_BIT];
            assign overlap_protect_off[gi] = st.module_input_control[gi][PSC_OVEN_BIT];
        end
    endgenerate

    // ------------------------------------------------------------
    // Fault response
    // ------------------------------------------------------------
    // Mode decoding per module; only active events with a non-ignore mode act.
    always_comb
    begin
        kill_a = 3'b000;
        kill_b = 3'b000;
        kill_all = 1'b0;
        halt_req = 1'b0;
        for (int i = 0; i < 3; i++)
        begin
            // With async control clear fault_evt (raw, or filtered if the filter bit is set) gates the pins at once;
            // with it set only the registered filter-domain event acts.
            logic act;
            act = st.module_input_control[i][PSC_AOC_BIT] ? st.filtered[i] == st.module_input_control[i][PSC_LEV_BIT]
                                                          : fault_evt[i];
            unique case (st.module_input_control[i][PSC_MODE_LSB +: 3])
                3'b000: ;
                3'b001: kill_a[i] = act;
                3'b010: kill_b[i] = act;
                3'b011:
                begin
                    kill_a[i] = act;
                    kill_b[i] = act;
                end
                3'b100, 3'b101: kill_all = kill_all | act;
                3'b110, 3'b111: halt_req = halt_req | act;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    // Gating then swap, then polarity; inactive level is the inverse of active.
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            logic ga;
            logic gb;
            ga = core_active.a[i] && st.running && !kill_a[i] && !kill_all;
            gb = core_active.b[i] && st.running && !kill_b[i] && !kill_all;
            gated.a[i] = st.run_control[PSC_SWAP_LSB + i] ? gb : ga;
            gated.b[i] = st.run_control[PSC_SWAP_LSB + i] ? ga : gb;
            module_out.a[i] = st.output_config[PSC_A_POL_BIT] ? gated.a[i] : !gated.a[i];
            module_out.b[i] = st.output_config[PSC_B_POL_BIT] ? gated.b[i] : !gated.b[i];
        end
    end

    // ------------------------------------------------------------
    // Flags and interrupt
    // ------------------------------------------------------------
    // Any mode other than ignore makes the event able to fault the module.
    always_comb
    begin
        set_flags[PSC_EOC_BIT] = core_cycle_end && st.running;
        for (int i = 0; i < 3; i++)
            set_flags[PSC_EV_LSB + i] = fault_evt[i] &&
                (st.module_input_control[i][PSC_MODE_LSB +: 3] != 3'b000);
        clr_flags = (wr_en && paddr == PSC_INTERRUPT_FLAGS_ADDR) ? pwdata[3:0] : 4'h0;
    end
    assign irq = |(st.interrupt_flags[3:0] & st.interrupt_mask[3:0]);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        // Register writes.
        if (wr_en)
        begin
            unique case (paddr)
                PSC_OUTPUT_CONFIG_ADDR: next_st.output_config = pwdata[7:0] & PSC_CONFIG_MASK;
                PSC_RUN_CONTROL_ADDR: next_st.run_control = pwdata[7:0];
                PSC_MODULE_INPUT0_ADDR: next_st.module_input_control[0] = pwdata[7:0];
                PSC_MODULE_INPUT1_ADDR: next_st.module_input_control[1] = pwdata[7:0];
                PSC_MODULE_INPUT2_ADDR: next_st.module_input_control[2] = pwdata[7:0];
                PSC_INTERRUPT_MASK_ADDR: next_st.interrupt_mask = pwdata[7:0] & PSC_IRQ_MASK;
                default: ;
            endcase
        end
        // Set wins over a clear in the same cycle.
        next_st.interrupt_flags = {4'h0, (st.interrupt_flags[3:0] & ~clr_flags) | set_flags};
        // Prescaler counter advances on source ticks while running.
        if (!st.running)
            next_st.div_count = 8'h00;
        else if (src_tick)
            next_st.div_count = (st.div_count == div_last) ? 8'h00 : st.div_count + 8'h01;
        // Input noise canceller: shift and change only on all-equal samples.
        for (int i = 0; i < 3; i++)
        begin
            next_st.samples[i] = {st.samples[i][PSC_FILTER_SAMPLES-2:0], raw_in[i]};
            if (&st.samples[i])
                next_st.filtered[i] = 1'b1;
            else if (~|st.samples[i])
                next_st.filtered[i] = 1'b0;
        end
        // Fault halt holds until software rewrites the run control register.
        if (halt_req)
            next_st.halted_fault = 1'b1;
        else if (wr_en && paddr == PSC_RUN_CONTROL_ADDR)
            next_st.halted_fault = 1'b0;
        // Run and halt, with optional completion of the cycle.
        if (halt_req || st.halted_fault)
            next_st.running = 1'b0;
        else if (st.run_control[PSC_RUN_BIT])
            next_st.running = 1'b1;
        else if (!st.run_control[PSC_CCYC_BIT] || core_cycle_end || !st.running)
            next_st.running = 1'b0;
        // Registered read data.
        next_st.prdata = 32'h0000_0000;
        if (rd_en)
        begin
            unique case (paddr)
                PSC_OUTPUT_CONFIG_ADDR: next_st.prdata[7:0] = st.output_config;
                PSC_RUN_CONTROL_ADDR: next_st.prdata[7:0] = st.run_control;
                PSC_MODULE_INPUT0_ADDR: next_st.prdata[7:0] = st.module_input_control[0];
                PSC_MODULE_INPUT1_ADDR: next_st.prdata[7:0] = st.module_input_control[1];
                PSC_MODULE_INPUT2_ADDR: next_st.prdata[7:0] = st.module_input_control[2];
                PSC_INTERRUPT_MASK_ADDR: next_st.prdata[7:0] = st.interrupt_mask;
                PSC_INTERRUPT_FLAGS_ADDR: next_st.prdata[7:0] = st.interrupt_flags;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st <= '0;
        else
            st <= next_st;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_flag_write;
        psel && penable && pwrite && pstrb[0] && paddr == PSC_INTERRUPT_FLAGS_ADDR;
    endsequence

    AST_EOC_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        (core_cycle_end && st.running) |=> st.interrupt_flags[PSC_EOC_BIT])
        else $error("cycle end flag not set");
    AST_FLAG_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (s_flag_write and pwdata[0] && !(core_cycle_end && st.running)) |=> !st.interrupt_flags[0])
        else $error("flag not cleared by write one");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(st.interrupt_flags[3:0] & st.interrupt_mask[3:0]))
        else $error("irq mismatch");
    AST_EV_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        set_flags[1] |=> st.interrupt_flags[1])
        else $error("event flag not set");
    AST_RUN_START: assert property (@(posedge pclk) disable iff (!presetn)
        (st.run_control[0] && !halt_req && !st.halted_fault) |=> st.running)
        else $error("run did not start");
    AST_CCYC: assert property (@(posedge pclk) disable iff (!presetn)
        (st.running && !st.run_control[0] && st.run_control[1] && !core_cycle_end && !halt_req
         && !st.halted_fault) |=> st.running)
        else $error("halted before cycle end");
    AST_FILTER: assert property (@(posedge pclk) disable iff (!presetn)
        (raw_in[0] [*6]) |-> st.filtered[0])
        else $error("filter did not follow");
    AST_POLARITY: assert property (@(posedge pclk) disable iff (!presetn)
        !st.running |-> module_out.a[0] == !st.output_config[PSC_A_POL_BIT])
        else $error("idle A level wrong");

endmodule : psc_ctrl

// ==== design/psc_pkg.sv ====
package psc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [11:0] PSC_OUTPUT_CONFIG_ADDR = 12'h000;
    localparam logic [11:0] PSC_RUN_CONTROL_ADDR = 12'h004;
    localparam logic [11:0] PSC_MODULE_INPUT0_ADDR = 12'h008;
    localparam logic [11:0] PSC_MODULE_INPUT1_ADDR = 12'h00C;
    localparam logic [11:0] PSC_MODULE_INPUT2_ADDR = 12'h010;
    localparam logic [11:0] PSC_INTERRUPT_MASK_ADDR = 12'h014;
    localparam logic [11:0] PSC_INTERRUPT_FLAGS_ADDR = 12'h018;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PSC_B_POL_BIT = 3;
    localparam int PSC_A_POL_BIT = 2;
    localparam int PSC_RUN_BIT = 0;
    localparam int PSC_CCYC_BIT = 1;
    localparam int PSC_SWAP_LSB = 2;
    localparam int PSC_CLKSEL_BIT = 5;
    localparam int PSC_DIV_LSB = 6;
    localparam int PSC_MODE_LSB = 0;
    localparam int PSC_AOC_BIT = 3;
    localparam int PSC_FILT_BIT = 4;
    localparam int PSC_LEV_BIT = 5;
    localparam int PSC_ISEL_BIT = 6;
    localparam int PSC_OVEN_BIT = 7;
    localparam int PSC_EOC_BIT = 0;
    localparam int PSC_EV_LSB = 1;

    // ------------------------------------------------------------
    // Reset values, masks and timing
    // ------------------------------------------------------------
    localparam logic [7:0] PSC_REG_RESET = 8'h00;
    localparam logic [7:0] PSC_CONFIG_MASK = 8'h0C;
    localparam logic [7:0] PSC_IRQ_MASK = 8'h0F;
    localparam int PSC_FILTER_SAMPLES = 4;
    localparam logic [7:0] PSC_DIV4_LAST = 8'h03;
    localparam logic [7:0] PSC_DIV32_LAST = 8'h1F;
    localparam logic [7:0] PSC_DIV256_LAST = 8'hFF;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] a;
        logic [2:0] b;
    } psc_outs_t;

    typedef struct packed {
        logic [7:0] output_config;
        logic [7:0] run_control;
        logic [2:0][7:0] module_input_control;
        logic [7:0] interrupt_mask;
        logic [7:0] interrupt_flags;
        logic [7:0] div_count;
        logic [2:0][PSC_FILTER_SAMPLES-1:0] samples;
        logic [2:0] filtered;
        logic halted_fault;
        logic running;
        logic [31:0] prdata;
    } psc_state_t;

endpackage : psc_pkg

// ==== dv/psc_stage_model.sv ====
`timescale 1ns/1ps

// Far side of the block: fault pins and comparators in front of the power stage.
module psc_stage_model
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Levels the bench asks the sources to show.
    input wire logic [2:0] pin_req,
    input wire logic [2:0] cmp_req,
    // Lines into the block.
    output logic [2:0] fault_input_pin,
    output logic [2:0] comparator_out
);
    // ------------------------------------------------------------
    // Source lines
    // ------------------------------------------------------------
    // The sources react one clock late, as a real comparator would settle.
    // At reset they rest high, which is no fault at the default low level.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_input_pin <= 3'h7;
            comparator_out <= 3'h7;
        end
        else
        begin
            fault_input_pin <= pin_req;
            comparator_out <= cmp_req;
        end
    end
endmodule : psc_stage_model

// ==== dv/psc_ctrl_tb.sv ====
`timescale 1ns/1ps

module psc_ctrl_tb;
    import psc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lerr;
    logic clk_pll_tick, clk_io_tick, core_cycle_end, core_tick, core_run, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv;
    logic [2:0] overlap_protect_off, fault_input_pin, comparator_out, pin_req, cmp_req;
    psc_outs_t core_active, module_out;
    int err_count, tests_run;

    psc_ctrl u_psc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_pll_tick(clk_pll_tick), .clk_io_tick(clk_io_tick),
        .core_active(core_active), .core_cycle_end(core_cycle_end), .core_tick(core_tick),
        .core_run(core_run), .overlap_protect_off(overlap_protect_off),
        .fault_input_pin(fault_input_pin), .comparator_out(comparator_out),
        .module_out(module_out), .irq(irq));

    psc_stage_model u_psc_stage_model (.pclk(pclk), .presetn(presetn), .pin_req(pin_req),
        .cmp_req(cmp_req), .fault_input_pin(fault_input_pin), .comparator_out(comparator_out));

    // Free-running 100 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("Checks run %0d, errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : print_verdict

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, want, seen);
        end
    endtask : check

    function automatic logic [31:0] w1(input logic v);
        return {31'h0, v};
    endfunction : w1

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // One APB transfer; read data and the error are taken at the edge where pready is high.
    task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 16)
            begin
                err_count++;
                print_verdict();
            end
            @(posedge pclk);
        end
        lerr = pslverr;
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        xfer(a, 1'b1, d);
    endtask : wr

    task automatic rd_chk(input string nm, input logic [11:0] a, input logic [7:0] want);
        xfer(a, 1'b0, 8'h00);
        check(nm, rdv, {24'h000000, want});
    endtask : rd_chk

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Reset values, writable bits, and an unmapped slot that must be refused.
    task automatic t_regs();
        for (int i = 0; i < 7; i++)
            rd_chk("reset value", 12'(i * 4), PSC_REG_RESET);
        wr(PSC_OUTPUT_CONFIG_ADDR, 8'hFF);
        rd_chk("output_config", PSC_OUTPUT_CONFIG_ADDR, PSC_CONFIG_MASK);
        wr(PSC_INTERRUPT_MASK_ADDR, 8'hFF);
        rd_chk("interrupt_mask", PSC_INTERRUPT_MASK_ADDR, PSC_IRQ_MASK);
        wr(PSC_INTERRUPT_MASK_ADDR, 8'h00);
        wr(PSC_MODULE_INPUT2_ADDR, 8'hB8);
        rd_chk("module_input_control", PSC_MODULE_INPUT2_ADDR, 8'hB8);
        xfer(12'h01C, 1'b1, 8'hFF);
        check("unmapped error", w1(lerr), 32'h1);
        rd_chk("no side effect", PSC_RUN_CONTROL_ADDR, 8'h00);
    endtask : t_regs

    // Every polarity pair, plain and swapped, on a non-overlapping pattern.
    task automatic t_pol();
        logic [2:0] ea, eb;
        core_active <= {3'h5, 3'h2};
        wr(PSC_RUN_CONTROL_ADDR, 8'h01);
        cyc(1);
        check("run", w1(core_run), 32'h1);
        for (int p = 0; p < 8; p++)
        begin
            wr(PSC_OUTPUT_CONFIG_ADDR, {4'h0, p[1:0], 2'h0});
            wr(PSC_RUN_CONTROL_ADDR, p[2] ? 8'h1D : 8'h01);
            ea = p[2] ? 3'h2 : 3'h5;
            eb = p[2] ? 3'h5 : 3'h2;
            ea = p[0] ? ea : ~ea;
            eb = p[1] ? eb : ~eb;
            check("module_out", 32'(module_out), {26'h0, ea, eb});
        end
    endtask : t_pol

    // Source select and every divider code; windows are whole multiples of the period.
    task automatic t_clk();
        logic [7:0] ctl [5] = '{8'h01, 8'h21, 8'h61, 8'hA1, 8'hE1};
        int win [5] = '{32, 32, 32, 64, 512};
        int want [5] = '{0, 32, 8, 2, 2};
        int n;
        clk_pll_tick <= 1'b1;
        for (int k = 0; k < 5; k++)
        begin
            wr(PSC_RUN_CONTROL_ADDR, ctl[k]);
            n = 0;
            repeat (win[k])
            begin
                @(posedge pclk);
                n += int'(core_tick === 1'b1);
            end
            check("tick count", 32'(n), 32'(want[k]));
        end
        clk_pll_tick <= 1'b0;
    endtask : t_clk

    // Plain halt, halt at cycle end, then the end-of-cycle flag and its interrupt.
    task automatic t_run();
        wr(PSC_RUN_CONTROL_ADDR, 8'h00);
        cyc(1);
        check("halt", w1(core_run), 32'h0);
        wr(PSC_RUN_CONTROL_ADDR, 8'h03);
        wr(PSC_RUN_CONTROL_ADDR, 8'h02);
        cyc(4);
        check("finish cycle", w1(core_run), 32'h1);
        core_cycle_end <= 1'b1;
        @(posedge pclk);
        core_cycle_end <= 1'b0;
        cyc(2);
        check("halt at end", w1(core_run), 32'h0);
        rd_chk("cycle flag", PSC_INTERRUPT_FLAGS_ADDR, 8'h01);
        check("irq masked", w1(irq), 32'h0);
        wr(PSC_INTERRUPT_MASK_ADDR, 8'h01);
        check("irq", w1(irq), 32'h1);
        wr(PSC_INTERRUPT_FLAGS_ADDR, 8'h01);
        rd_chk("flag cleared", PSC_INTERRUPT_FLAGS_ADDR, 8'h00);
        check("irq released", w1(irq), 32'h0);
        wr(PSC_INTERRUPT_MASK_ADDR, 8'h00);
    endtask : t_run

    // Every fault mode on module 0, low level, direct path; overlap guard off so A and B may both be active.
    task automatic t_fault();
        logic [5:0] dis [6] = '{6'h00, 6'h08, 6'h01, 6'h09, 6'h3F, 6'h3F};
        core_active <= 6'h3F;
        wr(PSC_OUTPUT_CONFIG_ADDR, 8'h00);
        wr(PSC_MODULE_INPUT1_ADDR, 8'h80);
        wr(PSC_MODULE_INPUT2_ADDR, 8'h80);
        for (int m = 0; m < 8; m++)
        begin
            wr(PSC_RUN_CONTROL_ADDR, 8'h01);
            wr(PSC_MODULE_INPUT0_ADDR, {5'h10, m[2:0]});
            check("overlap off", 32'(overlap_protect_off), 32'h7);
            pin_req[0] <= 1'b0;
            cyc(3);
            if (m < 6)
                check("module_out", 32'(module_out), 32'(dis[m]));
            else
                check("fault halt", w1(core_run), 32'h0);
            rd_chk("event flag", PSC_INTERRUPT_FLAGS_ADDR, m == 0 ? 8'h00 : 8'h02);
            pin_req[0] <= 1'b1;
            cyc(3);
            wr(PSC_INTERRUPT_FLAGS_ADDR, 8'h0F);
        end
        wr(PSC_RUN_CONTROL_ADDR, 8'h01);
        cyc(1);
        check("resume", w1(core_run), 32'h1);
    endtask : t_fault

    // Input select and high level on module 2, with its event interrupt enabled.
    task automatic t_select();
        wr(PSC_INTERRUPT_MASK_ADDR, 8'h08);
        cmp_req[2] <= 1'b1;
        pin_req[2] <= 1'b0;
        wr(PSC_MODULE_INPUT2_ADDR, 8'hA3);
        cyc(3);
        rd_chk("pin path quiet", PSC_INTERRUPT_FLAGS_ADDR, 8'h00);
        check("irq quiet", w1(irq), 32'h0);
        wr(PSC_MODULE_INPUT2_ADDR, 8'hE3);
        cyc(3);
        check("module_out", 32'(module_out), 32'h24);
        rd_chk("comparator event", PSC_INTERRUPT_FLAGS_ADDR, 8'h08);
        check("event irq", w1(irq), 32'h1);
        cmp_req[2] <= 1'b0;
        cyc(3);
        wr(PSC_INTERRUPT_FLAGS_ADDR, 8'h08);
        wr(PSC_INTERRUPT_MASK_ADDR, 8'h00);
    endtask : t_select

    // Filtered, registered path on module 1: one held level must not pass after 3 cycles, and must pass after 11.
    task automatic t_filter();
        wr(PSC_MODULE_INPUT1_ADDR, 8'h9B);
        pin_req[1] <= 1'b0;
        cyc(3);
        check("filter holds", 32'(module_out), 32'h00);
        cyc(8);
        check("filter passes", 32'(module_out), 32'h12);
        rd_chk("filtered event", PSC_INTERRUPT_FLAGS_ADDR, 8'h04);
    endtask : t_filter

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        clk_pll_tick = 1'b0;
        clk_io_tick = 1'b0;
        core_cycle_end = 1'b0;
        core_active = 6'h00;
        pin_req = 3'h7;
        cmp_req = 3'h7;
        err_count = 0;
        tests_run = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_pol();
        t_clk();
        t_run();
        t_fault();
        t_select();
        t_filter();
        print_verdict();
    end
endmodule : psc_ctrl_tb
